// File: logic/irq_regs.svh
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

// register indices; byte address is four times the index
`define IEM_IDX 8'ha8
`define IEX_IDX 8'hb1
`define PRH_IDX 8'hb7
`define PRL_IDX 8'hb8
`define PRX_IDX 8'hc0
`define STAT_IDX 8'hc1

`define IEM_RST 8'h00
`define IEX_RST 8'h00
`define PRH_RST 8'h00
`define PRL_RST 8'h00
`define PRX_RST 4'h0

`define IEM_GLOBAL_BIT 7
`define IEX_SPI_BIT 2
`define IEX_KEY_BIT 0
`define IEX_MASK 8'h05
`define PRIO_MASK 8'h7f

`define NUM_SRC 9
// polling position 0 in the low nibble
`define POLL_ORDER 36'h875463210

`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001b
`define VEC_SER 16'h0023
`define VEC_TMR2 16'h002b
`define VEC_CNT_ARR 16'h0033
`define VEC_KEY 16'h004b
`define VEC_SPI 16'h0043

`endif

// File: logic/irq_types_pkg.sv
package irq_types_pkg;

  typedef enum logic [3:0] {
    src_ext_zero = 4'h0,
    src_timer_zero = 4'h1,
    src_ext_one = 4'h2,
    src_timer_one = 4'h3,
    src_serial = 4'h4,
    src_timer_two = 4'h5,
    src_counter_array = 4'h6,
    src_keypad = 4'h7,
    src_spi = 4'h8
  } src_t;

  typedef logic [1:0] level_t;

endpackage

// File: logic/prio_pick.sv
`timescale 1ns/100ps
`include "irq_regs.svh"

module prio_pick
  import irq_types_pkg::*;
#(
  parameter int NUM_SRC = `NUM_SRC,
  parameter logic [35:0] POLL = `POLL_ORDER
) (
  input wire logic [NUM_SRC-1:0] elig,
  input wire logic [2*NUM_SRC-1:0] lvl,
  output logic found,
  output logic [3:0] win_idx,
  output level_t win_level
);

  logic [3:0] level_hit;
  logic [NUM_SRC-1:0] at_top;
  level_t top;

  genvar l;
  generate
    if (NUM_SRC != 9) begin : g_bad
      $error("prio_pick serves exactly nine sources");
    end
    for (l = 0; l < 4; l++) begin : g_lvl
      logic [NUM_SRC-1:0] m;
      always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
          m[s] = elig[s] && (lvl[2*s +: 2] == 2'(l));
        end
      end
      assign level_hit[l] = |m;
    end
  endgenerate

  // higher level beats lower level
  assign top = level_hit[3] ? 2'd3 : level_hit[2] ? 2'd2 : level_hit[1] ? 2'd1 : 2'd0;
  assign found = |level_hit;
  assign win_level = top;

  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) begin
      at_top[s] = elig[s] && (lvl[2*s +: 2] == top);
    end
  end

  // walk polling order backwards so the earliest poll position wins
  always_comb begin
    win_idx = 4'h0;
    for (int p = NUM_SRC - 1; p >= 0; p--) begin
      if (at_top[POLL[4*p +: 4]]) begin
        win_idx = POLL[4*p +: 4];
      end
    end
  end

endmodule

// File: logic/four_level_irq.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "irq_regs.svh"

// Notes on behaviour
// - nine request sources plus reset vector
// - cleared source enable blocks its request
// - cleared global enable blocks every request
// - each source has two priority bits
// - level is high bit then low bit
// - counter array, spi, keypad vector addresses
// - preempt only by strictly higher level
// - level three service is never preempted
// - higher level wins simultaneous requests
// - fixed polling order breaks level ties
// - main enable register bit layout
// - main enable resets zero, bit addressable; here written as a whole word only
// - low priority bits, reset zero
// - high priority bits, reset zero
// - reserved priority bits ignored, read zero
// - extension enable holds spi, keypad bits
// - extension enable resets low bits zero
// - polling order ends keypad then spi
// - standard vectors for remaining sources
module four_level_irq
  import irq_types_pkg::*;
#(
  parameter int NUM_SRC = `NUM_SRC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] src_flag,
  input wire logic vector_take,
  input wire logic reti,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output level_t irq_level,
  output logic [3:0] irq_src
);

  generate
    if (NUM_SRC != 9) begin : g_bad
      $error("four_level_irq serves exactly nine sources");
    end
  endgenerate

  logic [7:0] ien_main_r;
  logic [7:0] ien_ext_r;
  logic [7:0] prio_high_r;
  logic [7:0] prio_low_r;
  logic [3:0] prio_ext_r;
  logic [3:0] isr_r;
  logic [3:0] isr_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_req_r;
  logic irq_req_nxt;
  logic [15:0] irq_vector_r;
  level_t irq_level_r;
  logic [3:0] irq_src_r;

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready_r;
  wire aligned = paddr[1:0] == 2'b00;
  wire [7:0] idx = paddr[9:2];
  wire hit_iem = aligned && idx == `IEM_IDX;
  wire hit_iex = aligned && idx == `IEX_IDX;
  wire hit_prh = aligned && idx == `PRH_IDX;
  wire hit_prl = aligned && idx == `PRL_IDX;
  wire hit_prx = aligned && idx == `PRX_IDX;
  wire hit_stat = aligned && idx == `STAT_IDX;
  wire hit_any = hit_iem || hit_iex || hit_prh || hit_prl || hit_prx || hit_stat;
  wire wr_fire = access && pwrite && !pslverr_r;
  wire wr_iem = wr_fire && hit_iem;
  wire wr_iex = wr_fire && hit_iex;
  wire wr_prh = wr_fire && hit_prh;
  wire wr_prl = wr_fire && hit_prl;
  wire wr_prx = wr_fire && hit_prx;

  wire [31:0] rd_mux =
    hit_iem ? {24'h0, ien_main_r} :
    hit_iex ? {24'h0, ien_ext_r} :
    hit_prh ? {24'h0, prio_high_r} :
    hit_prl ? {24'h0, prio_low_r} :
    hit_prx ? {28'h0, prio_ext_r} :
    hit_stat ? {23'h0, irq_req_r, irq_src_r, isr_r} : 32'h0;

  // one wait-free access: ready rises in the access cycle of every transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // whole-word writes; single-bit set and clear is a read-modify-write by the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_main_r <= `IEM_RST;
      ien_ext_r <= `IEX_RST;
      prio_high_r <= `PRH_RST;
      prio_low_r <= `PRL_RST;
      prio_ext_r <= `PRX_RST;
    end else begin
      if (wr_iem) ien_main_r <= pwdata[7:0];
      if (wr_iex) ien_ext_r <= pwdata[7:0] & `IEX_MASK;
      if (wr_prh) prio_high_r <= pwdata[7:0] & `PRIO_MASK;
      if (wr_prl) prio_low_r <= pwdata[7:0] & `PRIO_MASK;
      if (wr_prx) prio_ext_r <= pwdata[3:0];
    end
  end

  // sources in enable-bit order, then keypad and spi
  wire [NUM_SRC-1:0] src_en = {ien_ext_r[`IEX_SPI_BIT], ien_ext_r[`IEX_KEY_BIT],
                               ien_main_r[6:0]};
  wire global_en = ien_main_r[`IEM_GLOBAL_BIT];
  // flags are taken as they stand this cycle, no extra staging
  wire [NUM_SRC-1:0] eligible = src_flag & src_en & {NUM_SRC{global_en}};

  logic [2*NUM_SRC-1:0] src_lvl;
  genvar s;
  generate
    for (s = 0; s < 7; s++) begin : g_lvl
      assign src_lvl[2*s +: 2] = {prio_high_r[s], prio_low_r[s]};
    end
  endgenerate
  assign src_lvl[15:14] = prio_ext_r[1:0];
  assign src_lvl[17:16] = prio_ext_r[3:2];

  logic found;
  logic [3:0] win_idx;
  level_t win_level;

  prio_pick #(
    .NUM_SRC(NUM_SRC),
    .POLL(`POLL_ORDER)
  ) u_pick (
    .elig(eligible),
    .lvl(src_lvl),
    .found(found),
    .win_idx(win_idx),
    .win_level(win_level)
  );

  // level of the service currently running; valid only when isr_r is nonzero
  wire busy = |isr_r;
  wire level_t active_level = isr_r[3] ? 2'd3 : isr_r[2] ? 2'd2 : isr_r[1] ? 2'd1 : 2'd0;
  wire allow = found && (!busy || win_level > active_level);

  function automatic logic [15:0] vector_of(input logic [3:0] src);
    unique case (src)
      src_ext_zero: vector_of = `VEC_EXT0;
      src_timer_zero: vector_of = `VEC_TMR0;
      src_ext_one: vector_of = `VEC_EXT1;
      src_timer_one: vector_of = `VEC_TMR1;
      src_serial: vector_of = `VEC_SER;
      src_timer_two: vector_of = `VEC_TMR2;
      src_counter_array: vector_of = `VEC_CNT_ARR;
      src_keypad: vector_of = `VEC_KEY;
      src_spi: vector_of = `VEC_SPI;
      default: vector_of = 16'h0000;
    endcase
  endfunction

  wire take = vector_take && irq_req_r;
  wire [3:0] take_set = take ? (4'h1 << irq_level_r) : 4'h0;
  wire [3:0] reti_clr = (reti && busy) ? (4'h1 << active_level) : 4'h0;

  // a take in the same cycle as a return still lands
  assign isr_nxt = (isr_r & ~reti_clr) | take_set;
  // request drops for one cycle after a take so the core never takes twice
  assign irq_req_nxt = allow && !take;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_r <= 4'h0;
      irq_req_r <= 1'b0;
      irq_vector_r <= 16'h0000;
      irq_level_r <= 2'd0;
      irq_src_r <= 4'h0;
    end else begin
      isr_r <= isr_nxt;
      irq_req_r <= irq_req_nxt;
      irq_vector_r <= vector_of(win_idx);
      irq_level_r <= win_level;
      irq_src_r <= win_idx;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_req = irq_req_r;
  assign irq_vector = irq_vector_r;
  assign irq_level = irq_level_r;
  assign irq_src = irq_src_r;

  // helper state for the checks below
  logic [NUM_SRC-1:0] elig_q;
  logic [2*NUM_SRC-1:0] lvl_q;
  logic [3:0] isr_q;
  logic global_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elig_q <= '0;
      lvl_q <= '0;
      isr_q <= 4'h0;
      global_q <= 1'b0;
    end else begin
      elig_q <= eligible;
      lvl_q <= src_lvl;
      isr_q <= isr_r;
      global_q <= global_en;
    end
  end

  wire level_t act_q = isr_q[3] ? 2'd3 : isr_q[2] ? 2'd2 : isr_q[1] ? 2'd1 : 2'd0;
  logic higher_waiting;
  always_comb begin
    higher_waiting = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig_q[i] && lvl_q[2*i +: 2] > irq_level_r) higher_waiting = 1'b1;
    end
  end

  a_global_gate: assert property (
    @(posedge pclk) disable iff (!presetn) irq_req_r |-> global_q)
    else $error("request raised while global enable was clear");

  a_source_enabled: assert property (
    @(posedge pclk) disable iff (!presetn) irq_req_r |-> elig_q[irq_src_r])
    else $error("request from a source that was not eligible");

  a_level_value: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r |-> irq_level_r == lvl_q[2*irq_src_r +: 2])
    else $error("reported level does not match priority bits");

  a_higher_first: assert property (
    @(posedge pclk) disable iff (!presetn) irq_req_r |-> !higher_waiting)
    else $error("a higher level request was passed over");

  a_strict_preempt: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && (isr_q != 4'h0) |-> irq_level_r > act_q)
    else $error("preemption by equal or lower level");

  a_top_level_holds: assert property (
    @(posedge pclk) disable iff (!presetn) isr_r[3] |=> !irq_req_r)
    else $error("level three service was preempted");

  a_take_marks: assert property (
    @(posedge pclk) disable iff (!presetn)
    vector_take && irq_req_r |=> isr_r[$past(irq_level_r)])
    else $error("taken level not marked in service");

  a_take_drops: assert property (
    @(posedge pclk) disable iff (!presetn) vector_take && irq_req_r |=> !irq_req_r)
    else $error("request stayed up after take");

  a_reti_pops: assert property (
    @(posedge pclk) disable iff (!presetn)
    reti && !vector_take && isr_r != 4'h0 |=> $countones(isr_r) == $countones(isr_q) - 1)
    else $error("return did not clear exactly one level");

  a_vector_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_spi |-> irq_vector_r == `VEC_SPI)
    else $error("wrong spi vector");

  a_apb_ready: assert property (
    @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready_r ##1 !pready_r)
    else $error("ready not a one-cycle answer to setup");

  a_vector_counter: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_counter_array |-> irq_vector_r == `VEC_CNT_ARR)
    else $error("wrong counter array vector");

  a_vector_keypad: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_keypad |-> irq_vector_r == `VEC_KEY)
    else $error("wrong keypad vector");

  a_vector_ext_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_ext_zero |-> irq_vector_r == `VEC_EXT0)
    else $error("wrong external line zero vector");

  a_vector_ext_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_ext_one |-> irq_vector_r == `VEC_EXT1)
    else $error("wrong external line one vector");

  a_vector_timer_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_timer_one |-> irq_vector_r == `VEC_TMR1)
    else $error("wrong timer one vector");

  a_vector_timer_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_timer_two |-> irq_vector_r == `VEC_TMR2)
    else $error("wrong timer two vector");

  a_vector_serial: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req_r && irq_src_r == src_serial |-> irq_vector_r == `VEC_SER)
    else $error("wrong serial vector");

  a_ext_reserved: assert property (
    @(posedge pclk) disable iff (!presetn) (ien_ext_r & ~`IEX_MASK) == 8'h00)
    else $error("reserved extension enable bit set");

  a_prio_reserved: assert property (
    @(posedge pclk) disable iff (!presetn) !prio_high_r[7] && !prio_low_r[7])
    else $error("reserved priority bit set");

  a_isr_steady: assert property (
    @(posedge pclk) disable iff (!presetn) !vector_take && !reti |=> isr_r == $past(isr_r))
    else $error("in-service flags moved without take or return");

  a_needs_eligible: assert property (
    @(posedge pclk) disable iff (!presetn) elig_q == '0 |-> !irq_req_r)
    else $error("request with nothing eligible");

  a_error_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn) pslverr_r |-> pready_r)
    else $error("error flagged outside the access cycle");

  a_rdata_idle: assert property (
    @(posedge pclk) disable iff (!presetn) !pready_r |-> prdata_r == 32'h0)
    else $error("read data not zero outside the access cycle");

endmodule

// File: tb/core_model.sv
`timescale 1ns/100ps

module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic take_en,
  input wire logic ret_go,
  output logic vector_take,
  output logic reti
);
  // one-shot claim: the stale request still high while vector_take is high is never claimed twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_take <= 1'b0;
      reti <= 1'b0;
    end else begin
      vector_take <= take_en & irq_req & ~vector_take;
      reti <= ret_go & ~reti;
    end
  end
endmodule

// File: tb/four_level_irq_test.sv
`timescale 1ns/100ps
`include "irq_regs.svh"

module four_level_irq_test;
  import irq_types_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] src_flag;
  logic vector_take, reti, irq_req, take_en, ret_go, er;
  logic [15:0] irq_vector;
  level_t irq_level;
  logic [3:0] irq_src;
  int err_count = 0;
  int compares = 0;
  logic [15:0] vec [9] = '{`VEC_EXT0, `VEC_TMR0, `VEC_EXT1, `VEC_TMR1, `VEC_SER,
    `VEC_TMR2, `VEC_CNT_ARR, `VEC_KEY, `VEC_SPI};
  int order [9] = '{0, 1, 2, 3, 6, 4, 5, 7, 8};

  four_level_irq four_level_irq_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_flag(src_flag), .vector_take(vector_take),
    .reti(reti), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .irq_src(irq_src));
  core_model core_model_inst (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .take_en(take_en), .ret_go(ret_go), .vector_take(vector_take), .reti(reti));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // waits for a presented request, then checks vector, level and source together
  task expect_req(input int s, input level_t lv);
    int i;
    for (i = 0; i < 40 && irq_req !== 1'b1; i++) @(posedge pclk) #1;
    if (irq_req !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    chk("irq_vector", irq_vector, vec[s]);
    chk("irq_level", irq_level, lv);
    chk("irq_src", irq_src, s);
  endtask

  task take();
    int i;
    @(posedge pclk);
    take_en <= 1'b1;
    for (i = 0; i < 20 && vector_take !== 1'b1; i++) @(posedge pclk) #1;
    if (vector_take !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    @(posedge pclk);
    take_en <= 1'b0;
  endtask

  task ret();
    @(posedge pclk);
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task quiet(input int n);
    int hit;
    hit = 0;
    repeat (n) begin
      @(posedge pclk) #1;
      if (irq_req !== 1'b0) hit++;
    end
    chk("irq_req quiet", hit, 0);
  endtask

  initial begin
    int k;
    level_t lv;
    {psel, penable, pwrite, take_en, ret_go} = '0;
    paddr = '0;
    pwdata = '0;
    src_flag = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (order[j]) begin
      apb(1'b0, j[1] ? (j[0] ? `PRL_IDX : `PRH_IDX) : (j[0] ? `IEX_IDX : `IEM_IDX), 0);
      if (j < 4) chk("reset value", rd[7:0], 8'h00);
    end
    apb(1'b0, 8'h10, 0);
    chk("unmapped error", er, 1'b1);
    $display("test reset done");
    // reserved bit 7 of the priority registers is never written as one
    apb(1'b1, `IEM_IDX, 32'hff);
    apb(1'b0, `IEM_IDX, 0);
    chk("enable main", rd[7:0], 8'hff);
    apb(1'b1, `IEX_IDX, 32'hff);
    apb(1'b0, `IEX_IDX, 0);
    chk("enable ext", rd[7:0], 8'h05);
    apb(1'b1, `PRH_IDX, 32'h7f);
    apb(1'b0, `PRH_IDX, 0);
    chk("prio high", rd[6:0], 7'h7f);
    apb(1'b1, `PRL_IDX, 32'h2a);
    apb(1'b0, `PRL_IDX, 0);
    chk("prio low", rd[6:0], 7'h2a);
    apb(1'b1, `PRX_IDX, 32'h9);
    apb(1'b0, `PRX_IDX, 0);
    chk("prio ext", rd[3:0], 4'h9);
    $display("test registers done");
    apb(1'b1, `IEM_IDX, 32'h7f);
    @(posedge pclk) src_flag <= 9'h1ff;
    quiet(10);
    apb(1'b1, `IEM_IDX, 32'h80);
    apb(1'b1, `IEX_IDX, 32'h00);
    quiet(10);
    @(posedge pclk) src_flag <= '0;
    apb(1'b1, `IEM_IDX, 32'hff);
    apb(1'b1, `IEX_IDX, 32'h05);
    $display("test gating done");
    for (k = 0; k < 9; k++) begin
      lv = level_t'(k % 4);
      apb(1'b1, `PRH_IDX, {25'h0, {7{lv[1]}}});
      apb(1'b1, `PRL_IDX, {25'h0, {7{lv[0]}}});
      apb(1'b1, `PRX_IDX, {28'h0, lv, lv});
      @(posedge pclk) src_flag <= 9'(1 << k);
      expect_req(k, lv);
      take();
      @(posedge pclk) src_flag <= '0;
      apb(1'b0, `STAT_IDX, 0);
      chk("in service", {rd[8], rd[3:0]}, {1'b0, 4'(1 << lv)});
      ret();
      apb(1'b0, `STAT_IDX, 0);
      chk("in service clear", rd[3:0], 4'h0);
    end
    $display("test vectors done");
    apb(1'b1, `PRH_IDX, 0);
    apb(1'b1, `PRL_IDX, 0);
    apb(1'b1, `PRX_IDX, 0);
    @(posedge pclk) src_flag <= 9'h1ff;
    for (k = 0; k < 9; k++) begin
      expect_req(order[k], 2'd0);
      take();
      @(posedge pclk) src_flag[order[k]] <= 1'b0;
      ret();
    end
    $display("test polling done");
    apb(1'b1, `PRH_IDX, 32'h08);
    apb(1'b1, `PRL_IDX, 32'h10);
    apb(1'b1, `PRX_IDX, 32'h0c);
    @(posedge pclk) src_flag <= 9'h019;
    expect_req(3, 2'd2);
    take();
    quiet(8);
    @(posedge pclk) src_flag[8] <= 1'b1;
    expect_req(8, 2'd3);
    take();
    @(posedge pclk) src_flag[8] <= 1'b0;
    apb(1'b1, `PRH_IDX, 32'h09);
    apb(1'b1, `PRL_IDX, 32'h11);
    quiet(8);
    ret();
    expect_req(0, 2'd3);
    $display("test nesting done");
    give_verdict();
  end
endmodule
